// ==== bfp_fault_protect.sv ====
// Fault protection logic that forces the bridge outputs off on faults.
`timescale 1ns/100ps
// Notes on behaviour
// - While the over-temperature flag is high every bridge output is off.
// - After a thermal trip, outputs return only once the release flag is high and the trip flag is low.
// - An accepted over-current turns all outputs off and latches the fault.
// - Over-current pulses shorter than the dead band are ignored.
// - Sleep input low then high clears the over-current latch.
// - A power-on reset also clears the over-current latch.
// - While the supply-low flag is high all outputs are held off.
// - The supply lockout releases by itself once the flag drops.
module bfp_fault_protect
  import bfp_pkg::*;
#(
  parameter int unsigned DEAD_BAND = DEAD_BAND_CYC
) (
  // Clock and reset
  input  wire logic                        I_REF_CLK,
  input  wire logic                        I_NRST,
  // Comparator flags, asynchronous
  input  wire bfp_pkg::bfp_flags_t         I_FLAGS,
  // Host control
  input  wire logic                        I_SLEEP_CONTROL_INPUT_N,
  input  wire logic [bfp_pkg::NUM_OUTS-1:0] I_DRIVE,
  // Bridge outputs and status
  output logic      [bfp_pkg::NUM_OUTS-1:0] O_BRIDGE,
  output logic                             O_DISABLE,
  output bfp_pkg::bfp_status_t             O_STATUS
);
  import bfp_pkg::*;

  localparam int unsigned CW = $clog2(DEAD_BAND + 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [CW-1:0] CNT_MAX  = CW'(DEAD_BAND);

  bfp_flags_t         flags_s;
  logic               sleep_n_s;
  logic [NUM_OUTS-1:0] drive_s;

  // Flags, sleep and drive come from pins, so all are synchronised.
  bfp_sync #(.WIDTH(NUM_FLAGS), .RST_VAL(FLAGS_RST)) u_flag_sync (
    .clk   (I_REF_CLK),
    .rst_n (I_NRST),
    .d     (I_FLAGS),
    .q     (flags_s)
  );

  bfp_sync #(.WIDTH(NUM_OUTS + 1), .RST_VAL('0)) u_ctl_sync (
    .clk   (I_REF_CLK),
    .rst_n (I_NRST),
    .d     ({I_SLEEP_CONTROL_INPUT_N, I_DRIVE}),
    .q     ({sleep_n_s, drive_s})
  );

  logic               therm_reg;
  logic               therm_next;
  logic               lowsup_reg;
  logic               lowsup_next;
  logic [CW-1:0]      db_cnt_reg;
  logic [CW-1:0]      db_cnt_next;
  bfp_oc_state_t      oc_state_reg;
  bfp_oc_state_t      oc_state_next;
  logic               oc_hit;
  logic               dis_next;
  logic [NUM_OUTS-1:0] bridge_next;
  bfp_status_t        status_next;

  // Thermal hysteresis: trip sets, only the release flag clears.
  always_comb begin
    therm_next = therm_reg;
    if (flags_s.thermal_trip) begin
      therm_next = 1'b1;
    end else if (flags_s.thermal_release) begin
      therm_next = 1'b0;
    end
  end

  // Supply lockout follows the flag with no memory.
  always_comb begin
    lowsup_next = flags_s.supply_low;
  end

  // Dead band filter; counting stops at the limit.
  always_comb begin
    db_cnt_next = CNT_ZERO;
    if (flags_s.overcurrent) begin
      if (db_cnt_reg == CNT_MAX) begin
        db_cnt_next = db_cnt_reg;
      end else begin
        db_cnt_next = db_cnt_reg + CNT_ONE;
      end
    end
    oc_hit = flags_s.overcurrent && (db_cnt_reg == CNT_MAX - CNT_ONE);
  end

  // Over-current latch; only a sleep pulse or reset clears it.
  always_comb begin
    oc_state_next = oc_state_reg;
    case (oc_state_reg)
      BFP_RUN: begin
        if (!sleep_n_s) begin
          oc_state_next = BFP_SLEEP;
        end else if (oc_hit) begin
          oc_state_next = BFP_OC_LATCH;
        end
      end
      BFP_OC_LATCH: begin
        if (!sleep_n_s) begin
          oc_state_next = BFP_SLEEP;
        end
      end
      BFP_SLEEP: begin
        if (sleep_n_s) begin
          oc_state_next = BFP_RUN;
        end
      end
      default: begin
        oc_state_next = BFP_OC_LATCH;
      end
    endcase
  end

  // Sleep also turns the bridge off; it is not counted as a fault.
  always_comb begin
    status_next.thermal_trip       = therm_next;
    status_next.supply_low_lockout = lowsup_next;
    status_next.overcurrent_trip   = (oc_state_next == BFP_OC_LATCH);
    dis_next = therm_next | lowsup_next |
               (oc_state_next == BFP_OC_LATCH);
    if (dis_next || oc_state_next == BFP_SLEEP) begin
      bridge_next = OUTS_OFF;
    end else begin
      bridge_next = drive_s;
    end
  end

  // Reset leaves the latch clear, which is the power-on clearing path.
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      therm_reg    <= 1'b0;
      lowsup_reg   <= 1'b0;
      db_cnt_reg   <= CNT_ZERO;
      oc_state_reg <= BFP_RUN;
      O_BRIDGE     <= OUTS_OFF;
      O_DISABLE    <= 1'b0;
      O_STATUS     <= '0;
    end else begin
      therm_reg    <= therm_next;
      lowsup_reg   <= lowsup_next;
      db_cnt_reg   <= db_cnt_next;
      oc_state_reg <= oc_state_next;
      O_BRIDGE     <= bridge_next;
      O_DISABLE    <= dis_next;
      O_STATUS     <= status_next;
    end
  end
endmodule

// ==== bfp_pkg.sv ====
// Package with constants and carrier types for the bridge fault protection.
package bfp_pkg;
  localparam int unsigned REF_CLK_HZ      = 40_000_000;
  localparam int unsigned DEAD_BAND_NS    = 1500;
  // Least time, so the count rounds up.
  localparam int unsigned DEAD_BAND_CYC   =
    (DEAD_BAND_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SYNC_STAGES     = 2;
  localparam int unsigned NUM_FLAGS       = 4;
  localparam int unsigned NUM_OUTS        = 4;
  localparam int unsigned FLAG_THERM_TRIP = 0;
  localparam int unsigned FLAG_THERM_REL  = 1;
  localparam int unsigned FLAG_OVERCUR    = 2;
  localparam int unsigned FLAG_SUPPLY_LOW = 3;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST  = 4'h0;
  localparam logic [NUM_OUTS-1:0]  OUTS_OFF   = 4'h0;

  typedef struct packed {
    logic supply_low;
    logic overcurrent;
    logic thermal_release;
    logic thermal_trip;
  } bfp_flags_t;

  typedef struct packed {
    logic thermal_trip;
    logic supply_low_lockout;
    logic overcurrent_trip;
  } bfp_status_t;

  typedef enum logic [1:0] {
    BFP_RUN     = 2'b00,
    BFP_OC_LATCH = 2'b01,
    BFP_SLEEP   = 2'b10
  } bfp_oc_state_t;
endpackage

// ==== bfp_sync.sv ====
// Two-stage synchronizer for a vector of asynchronous levels.
`timescale 1ns/100ps
module bfp_sync #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule

// ==== bfp_chk.sv ====
// Assertions on the ports of the fault protection.
`timescale 1ns/100ps
module bfp_chk
  import bfp_pkg::*;
#(parameter int unsigned DEAD_BAND = DEAD_BAND_CYC) (
  input wire logic        I_REF_CLK, I_NRST, I_SLEEP_CONTROL_INPUT_N,
  input wire bfp_flags_t  I_FLAGS,
  input wire logic [NUM_OUTS-1:0] O_BRIDGE,
  input wire logic        O_DISABLE,
  input wire bfp_status_t O_STATUS
);
  int unsigned cnt_reg;
  // Counts raw samples, so it runs two cycles ahead of the design's count.
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
    if (!I_NRST) cnt_reg <= 0;
    else cnt_reg <= I_FLAGS.overcurrent ? cnt_reg + 1 : 0;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  AST_THERM_OFF: assert property (I_FLAGS.thermal_trip [*3] |=>
    O_DISABLE && O_STATUS.thermal_trip && ~|O_BRIDGE) else $error("hot");
  AST_THERM_HOLD: assert property (!I_FLAGS.thermal_release [*3] ##0
    O_STATUS.thermal_trip |=> O_STATUS.thermal_trip) else $error("cool");
  AST_OC_OFF: assert property ($rose(O_STATUS.overcurrent_trip) |->
    O_DISABLE && ~|O_BRIDGE) else $error("latch");
  AST_OC_BAND: assert property ($rose(O_STATUS.overcurrent_trip) |->
    $past(cnt_reg, 2) >= DEAD_BAND) else $error("band");
  AST_OC_CLR: assert property (!I_SLEEP_CONTROL_INPUT_N [*3] |=>
    !O_STATUS.overcurrent_trip && ~|O_BRIDGE) else $error("sleep");
  AST_LOW_OFF: assert property (I_FLAGS.supply_low [*3] |=>
    O_DISABLE && O_STATUS.supply_low_lockout && ~|O_BRIDGE) else $error("low");
  AST_LOW_REL: assert property (!I_FLAGS.supply_low [*3] |=>
    !O_STATUS.supply_low_lockout) else $error("lockout");
  AST_OR: assert property (O_DISABLE == |O_STATUS &&
    (!O_DISABLE || ~|O_BRIDGE)) else $error("disable");
  AST_SYNC: assert property ($stable(I_FLAGS.supply_low) [*3] ##1
    $changed(I_FLAGS.supply_low) |=> $stable(O_STATUS.supply_low_lockout))
    else $error("sync");
endmodule
bind bfp_fault_protect bfp_chk #(.DEAD_BAND(DEAD_BAND)) chk (.I_REF_CLK,
  .I_NRST, .I_SLEEP_CONTROL_INPUT_N, .I_FLAGS, .O_BRIDGE, .O_DISABLE,
  .O_STATUS);

// ==== bfp_host.sv ====
// Host model that takes the part through standby and back.
`timescale 1ns/100ps
module bfp_host (
  input wire logic clk, go,
  output logic     sleep_n = 1'b1
);
  always @(posedge go) begin
    sleep_n = 1'b0;
    repeat (4) @(negedge clk);
    sleep_n = 1'b1;
  end
endmodule

// ==== test_bfp_fault_protect.sv ====
// Self-checking testbench of the bridge fault protection.
`timescale 1ns/100ps
module test_bfp_fault_protect;
  import bfp_pkg::*;
  logic        I_REF_CLK = 0, I_NRST = 0, go = 0, sleep_n, O_DISABLE;
  logic [3:0]  I_DRIVE, O_BRIDGE, d;
  bfp_flags_t  I_FLAGS = '0;
  bfp_status_t O_STATUS;
  logic [7:0]  q[$], e;
  int          miscompares = 0, comparisons = 0, seed = 32'h28f0;
  event        ev;
  always #12.5 I_REF_CLK = ~I_REF_CLK;
  bfp_fault_protect #(.DEAD_BAND(4)) dut (.I_REF_CLK, .I_NRST, .I_FLAGS,
    .I_SLEEP_CONTROL_INPUT_N(sleep_n), .I_DRIVE, .O_BRIDGE, .O_DISABLE,
    .O_STATUS);
  bfp_host host (.clk(I_REF_CLK), .go, .sleep_n);
  always @(ev) begin
    e = q.pop_front();
    comparisons++;
    if ({O_BRIDGE, O_DISABLE, O_STATUS} !== e) begin
      miscompares++;
      $display("CHECK FAILED outputs exp %h seen %h", e,
        {O_BRIDGE, O_DISABLE, O_STATUS});
    end
  end
  // Outputs are registered, so a negedge sample never races the drivers.
  task chk(input logic [3:0] b, s, input int n);
    repeat (n) @(negedge I_REF_CLK);
    q.push_back({b, s});
    -> ev;
  endtask
  task complete_run;
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    d = 4'($random(seed)) | 4'h1;
    I_DRIVE = d;
    repeat (6) @(negedge I_REF_CLK);
    I_NRST = 1;
    chk(d, 4'h0, 8);
    I_FLAGS.thermal_trip = 1;
    chk(4'h0, 4'hc, 4);
    I_FLAGS.thermal_trip = 0;
    chk(4'h0, 4'hc, 4);
    I_FLAGS.thermal_release = 1;
    chk(d, 4'h0, 4);
    I_FLAGS = 4'h8;
    chk(4'h0, 4'ha, 4);
    I_FLAGS = '0;
    chk(d, 4'h0, 4);
    I_FLAGS.overcurrent = 1;
    chk(d, 4'h0, 3);
    I_FLAGS.overcurrent = 0;
    chk(d, 4'h0, 8);
    I_FLAGS.overcurrent = 1;
    chk(4'h0, 4'h9, 12);
    I_FLAGS.overcurrent = 0;
    chk(4'h0, 4'h9, 8);
    go = 1;
    chk(4'h0, 4'h0, 4);
    go = 0;
    chk(d, 4'h0, 4);
    I_FLAGS.overcurrent = 1;
    chk(4'h0, 4'h9, 12);
    I_FLAGS.overcurrent = 0;
    I_NRST = 0;
    chk(4'h0, 4'h0, 2);
    d = 4'($random(seed)) | 4'h1;
    I_DRIVE = d;
    I_NRST = 1;
    chk(d, 4'h0, 8);
    complete_run;
  end
endmodule
